/* File: hw/lvds_sample_input_port.sv */
// Sample input port: serial register access and double-rate capture.
`timescale 1ns/1ps
module lvds_sample_input_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic forwarded_data_clock,
  input wire lvds_port_pkg::link_in_t lvds,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic [3:0] sampling_phase_steps,
  output lvds_port_pkg::sample_out_t samples
);
  import lvds_port_pkg::*;

  ctl_t s_q;
  ctl_t s_d;
  link_t l_q;
  link_t l_d;
  logic [15:0] f_data_q;
  logic f_frame_q;
  logic rise;
  logic fall;
  logic sdi;

  function automatic logic [15:0] to_twos(input logic [15:0] x,
                                          input logic ob);
    to_twos = ob ? {~x[15], x[14:0]} : x;
  endfunction

  // Steps of 11.25 degrees; eight steps make the nominal 90 degrees.
  function automatic logic [3:0] phase_steps(input logic [3:0] p);
    logic [2:0] mag;
    mag = (p[2:0] > MAX_MAG) ? MAX_MAG : p[2:0];
    phase_steps = p[PHASE_SIGN_BIT] ? 4'(NOM_STEPS - 4'(mag))
                                    : 4'(NOM_STEPS + 4'(mag));
  endfunction

  // Unmapped addresses read as zero and drop writes, so a stray access
  // cannot disturb the link settings.
  function automatic logic [7:0] read_mux(input logic [14:0] a,
                                          input ctl_t c);
    read_mux = 8'h00;
    if (a == ADDR_PHASE) begin
      read_mux = c.phase;
    end else if (a == ADDR_CFG) begin
      read_mux = c.cfg;
    end
  endfunction

  // ***********************************************************
  // Serial register port
  // ***********************************************************
  // The serial pins are oversampled, so the serial clock must run well
  // below a sixth of the system clock for every edge to be seen.
  always_comb begin
    s_d = s_q;
    rise = s_q.sy2.sclk & ~s_q.prev.sclk;
    fall = ~s_q.sy2.sclk & s_q.prev.sclk;
    sdi = s_q.sy2.sdio;
    if (ce) begin
      s_d.sy1 = '{sclk: sclk, cs_n: cs_n, sdio: sdio_in};
      s_d.sy2 = s_q.sy1;
      s_d.prev = s_q.sy2;
      if (s_q.sy2.cs_n) begin
        s_d.cnt = 5'h00;
        s_d.oe = 1'b0;
      end else begin
        if (rise && s_q.cnt < XFER_BITS) begin
          s_d.cnt = 5'(s_q.cnt + 5'h01);
          s_d.sh = {s_q.sh[13:0], sdi};
          if (s_q.cnt == INSTR_BITS - 5'h01) begin
            s_d.rw = s_q.sh[14];
            s_d.addr = {s_q.sh[13:0], sdi};
            s_d.rd = read_mux({s_q.sh[13:0], sdi}, s_q);
          end
          if (s_q.cnt == XFER_BITS - 5'h01 && !s_q.rw) begin
            if (s_q.addr == ADDR_PHASE) begin
              s_d.phase = {s_q.sh[6:0], sdi}; // RULE16
            end else if (s_q.addr == ADDR_CFG) begin
              s_d.cfg = {s_q.sh[6:0], sdi}; // RULE2
            end
          end
        end
        if (fall && s_q.rw && s_q.cnt >= INSTR_BITS &&
            s_q.cnt < XFER_BITS) begin
          s_d.sdo = s_q.rd[7];
          s_d.rd = {s_q.rd[6:0], 1'b0};
          s_d.oe = 1'b1;
        end
      end
      s_d.dll = phase_steps(s_q.phase[3:0]); // RULE12 RULE15 RULE17
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
      s_q.dll <= NOM_STEPS;
      s_q.phase <= PHASE_RESET;
      s_q.cfg <= CFG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ***********************************************************
  // Link capture
  // ***********************************************************
  // The delay line places the clock edges in the eye centre; this logic
  // sees those edges on its clock port and captures on both of them.
  always_ff @(negedge forwarded_data_clock) begin
    f_data_q <= lvds.data; // RULE13
    f_frame_q <= lvds.frame; // RULE19
  end

  always_comb begin
    l_d = l_q;
    l_d.rs1 = rst;
    l_d.rs2 = l_q.rs1;
    l_d.cf1 = {s_q.cfg[CFG_FMT_BIT], s_q.cfg[CFG_BYTE_BIT]};
    l_d.cf2 = l_q.cf1;
    l_d.rdat = lvds.data; // RULE13
    l_d.rfr = lvds.frame; // RULE19
    l_d.last = f_frame_q;
    l_d.out.valid = 1'b0;
    if (l_q.rs2) begin
      l_d.locked = 1'b0;
      l_d.odd = 1'b0;
      l_d.last = 1'b0;
      l_d.out = '0;
    end else if (!l_q.cf2[0]) begin
      // Rising-edge word first, then the falling-edge word.
      l_d.locked = 1'b0;
      l_d.out.valid = 1'b1; // RULE3
      l_d.out.two = 1'b1;
      l_d.out.s0 = to_twos(l_q.rdat, l_q.cf2[1]); // RULE1 RULE10
      l_d.out.s1 = to_twos(f_data_q, l_q.cf2[1]); // RULE1 RULE10
    end else begin
      l_d.out.two = 1'b0;
      l_d.out.s1 = 16'h0000;
      if (!l_q.locked) begin
        // Only the first rise of the marker fixes the byte order.
        if (l_q.rfr && !l_q.last) begin
          l_d.locked = 1'b1; // RULE6 RULE7
          l_d.odd = 1'b0;
          l_d.out.valid = 1'b1;
          l_d.out.s0 = to_twos({l_q.rdat[7:0], f_data_q[7:0]},
                               l_q.cf2[1]); // RULE1
        end else if (f_frame_q && !l_q.rfr) begin
          l_d.locked = 1'b1; // RULE6 RULE7
          l_d.odd = 1'b1;
          l_d.held = f_data_q[7:0];
        end
      end else if (!l_q.odd) begin
        l_d.out.valid = 1'b1;
        l_d.out.s0 = to_twos({l_q.rdat[7:0], f_data_q[7:0]},
                             l_q.cf2[1]); // RULE1 RULE10
      end else begin
        l_d.out.valid = 1'b1;
        l_d.out.s0 = to_twos({l_q.held, l_q.rdat[7:0]},
                             l_q.cf2[1]); // RULE1 RULE10
        l_d.held = f_data_q[7:0];
      end
    end
  end

  // The reset and configuration arrive through the first four fields,
  // which form a plain two-flop synchroniser for quasi-static levels.
  // Mode and format are not sampled as one word, so a write that flips
  // both may show one link cycle of mixed settings; change them only
  // while the host holds the link idle.
  always_ff @(posedge forwarded_data_clock) begin
    l_q <= l_d;
  end

  assign sdio_out = s_q.sdo;
  assign sdio_oe = s_q.oe;
  assign sampling_phase_steps = s_q.dll;
  assign samples = l_q.out;

  // ***********************************************************
  // Checks
  // ***********************************************************
  a_phase_nominal: assert property ( // RULE15
    @(posedge clock) disable iff (rst)
    ce && s_q.phase[3:0] == 4'h0 |=> sampling_phase_steps == 4'h8)
    else $error("zero offset did not give 90 degrees");

  a_phase_offset: assert property ( // RULE17
    @(posedge clock) disable iff (rst)
    ce && s_q.phase[2:0] < 3'h7 |=> sampling_phase_steps ==
      ($past(s_q.phase[3]) ? 4'(4'h8 - $past(s_q.phase[2:0]))
                           : 4'(4'h8 + $past(s_q.phase[2:0]))))
    else $error("phase step does not follow the setting");

  a_cfg_write: assert property ( // RULE2
    @(posedge clock) disable iff (rst)
    ce && !s_q.sy2.cs_n && rise && s_q.cnt == 5'h17 && !s_q.rw &&
      s_q.addr == ADDR_CFG |=> s_q.cfg == $past({s_q.sh[6:0], sdi}))
    else $error("config write lost");

  a_sdio_release: assert property ( // RULE16
    @(posedge clock) disable iff (rst)
    ce && s_q.sy2.cs_n |=> !sdio_oe)
    else $error("data pin driven while deselected");

  a_word_ddr_pair: assert property ( // RULE13
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    !l_q.cf2[0] && !l_q.cf2[1] |=> samples.valid && samples.two &&
      samples.s0 == $past(l_q.rdat) && samples.s1 == $past(f_data_q))
    else $error("word pair not taken from both edges");

  a_format_msb: assert property ( // RULE10
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    !l_q.cf2[0] |=> samples.s0[15] ==
      ($past(l_q.rdat[15]) ^ $past(l_q.cf2[1])))
    else $error("number format not applied");

  a_first_edge_even: assert property ( // RULE6
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    l_q.cf2[0] && !l_q.locked && l_q.rfr && !l_q.last
    |=> samples.valid && !samples.two &&
      samples.s0 == ({$past(l_q.rdat[7:0]), $past(f_data_q[7:0])} ^
        {$past(l_q.cf2[1]), 15'h0000}))
    else $error("byte pair not aligned to marker rise");

  a_odd_pairing: assert property ( // RULE7
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    l_q.cf2[0] && l_q.locked && l_q.odd
    |=> samples.s0 == ({$past(l_q.held), $past(l_q.rdat[7:0])} ^
      {$past(l_q.cf2[1]), 15'h0000}))
    else $error("odd byte pairing broken");

  a_lock_holds: assert property ( // RULE7
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    l_q.cf2[0] && l_q.locked ##1 l_q.cf2[0] |-> l_q.locked)
    else $error("later marker edges disturbed the lock");

  c_word_stream: cover property (
    @(posedge forwarded_data_clock) samples.valid && samples.two [*4]);

  c_odd_lock: cover property (
    @(posedge forwarded_data_clock) l_q.locked && l_q.odd &&
      samples.valid);

  c_reg_read: cover property (
    @(posedge clock) s_q.rw && sdio_oe && s_q.cnt == 5'h18);

  // ***********************************************************
  // Register and phase checks
  // ***********************************************************
  // A write that does not land must leave the configuration untouched; this
  // also shows that a low clock enable keeps the config register frozen.
  a_phase_write: assert property ( // RULE16
    @(posedge clock) disable iff (rst)
    ce && !s_q.sy2.cs_n && rise && s_q.cnt == 5'h17 && !s_q.rw &&
      s_q.addr == ADDR_PHASE |=> s_q.phase == $past({s_q.sh[6:0], sdi}))
    else $error("phase write lost");

  a_cfg_hold: assert property ( // RULE2
    @(posedge clock) disable iff (rst)
    !(ce && !s_q.sy2.cs_n && rise && s_q.cnt == 5'h17 && !s_q.rw &&
      s_q.addr == ADDR_CFG) |=> $stable(s_q.cfg))
    else $error("config changed without a write");

  // Magnitude seven is outside the usable range and is clamped to six.
  a_phase_clamp: assert property ( // RULE17
    @(posedge clock) disable iff (rst)
    ce && s_q.phase[2:0] == 3'h7 |=>
      sampling_phase_steps == ($past(s_q.phase[3]) ? 4'h2 : 4'he))
    else $error("phase magnitude not clamped");

  a_steps_range: assert property ( // RULE17
    @(posedge clock) disable iff (rst)
    ce |=> sampling_phase_steps >= 4'h2 && sampling_phase_steps <= 4'he)
    else $error("phase step outside the delay line range");

  // Read bits follow each seen falling edge of the serial clock, so the
  // host has most of a serial bit time to sample them.
  a_rd_shift: assert property ( // RULE16
    @(posedge clock) disable iff (rst)
    ce && !s_q.sy2.cs_n && fall && s_q.rw && s_q.cnt >= 5'h10 &&
      s_q.cnt < 5'h18 |=> sdio_oe && sdio_out == $past(s_q.rd[7]))
    else $error("read bit not driven after falling edge");

  // ***********************************************************
  // Link checks
  // ***********************************************************
  // The link reset has no disable of its own: it is the event checked.
  a_link_reset: assert property ( // RULE7
    @(posedge forwarded_data_clock)
    l_q.rs2 |=> samples == '0 && !l_q.locked)
    else $error("link reset did not clear the output");

  a_word_two: assert property ( // RULE3
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    !l_q.cf2[0] |=> samples.valid && samples.two)
    else $error("word mode missed a sample pair");

  a_word_unlocks: assert property ( // RULE7
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    !l_q.cf2[0] |=> !l_q.locked)
    else $error("byte lock survived word mode");

  a_byte_single: assert property ( // RULE1
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    l_q.cf2[0] |=> !samples.two && samples.s1 == 16'h0000)
    else $error("byte mode produced a second sample");

  // In byte mode, before the first marker rise nothing may leave the port, since the
  // byte order is still unknown.
  a_unlocked_quiet: assert property ( // RULE6
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    l_q.cf2[0] && !l_q.locked && !(l_q.rfr && !l_q.last) |=>
      !samples.valid)
    else $error("sample left before the byte order was known");

  a_even_lock_start: assert property ( // RULE6
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    l_q.cf2[0] && !l_q.locked && l_q.rfr && !l_q.last |=>
      l_q.locked && !l_q.odd)
    else $error("marker rise on a rising edge not locked");

  a_odd_lock_start: assert property ( // RULE6
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    l_q.cf2[0] && !l_q.locked && !l_q.rfr && f_frame_q |=>
      l_q.locked && l_q.odd && !samples.valid)
    else $error("marker rise on a falling edge not locked");

  a_byte_lower_lanes: assert property ( // RULE1
    @(posedge forwarded_data_clock) disable iff (l_q.rs2)
    l_q.cf2[0] && l_q.locked && !l_q.odd |=>
      samples.s0[7:0] == $past(f_data_q[7:0]))
    else $error("lower byte not taken from the lower lanes");

  c_even_lock: cover property (
    @(posedge forwarded_data_clock) l_q.locked && !l_q.odd &&
      samples.valid && !samples.two);

  c_phase_neg: cover property (
    @(posedge clock) s_q.phase[3] && sampling_phase_steps < 4'h8);
endmodule

/* File: pkg/lvds_port_pkg.sv */
// Constants and types for the sample input port.
// Overview of operation
// [RULE1] Word mode takes all sixteen lanes; byte mode only the lower eight.
// [RULE2] Config register input_port_config bit 0 high selects byte mode, low word mode.
// [RULE3] Word mode derives a double-rate sampling clock from the data clock.
// [RULE4] Host drives the forwarded clock time-aligned with the data lanes.
// [RULE5] Host sends upper byte then lower byte of each sample.
// [RULE6] Host sends aligned frame marker; its rising edge marks an upper byte.
// [RULE7] Single or repeating marker accepted; only the first rise sets order.
// [RULE8] A single frame pulse stays high at least one clock period.
// [RULE9] A repeating marker runs at clock rate over twice an integer.
// [RULE10] Config register input_port_config bit 7 selects offset binary or twos complement.
// [RULE11] Host sends sixteen-bit data with a double-rate forwarded clock.
// [RULE12] Delay loop runs from 250 to 575 MHz, gives shifted sampling clock.
// [RULE13] Data is registered on both edges of the sampling clock.
// [RULE14] Host keeps clock edges coincident with data bit transitions; the host model moves the lanes a quarter period after each edge.
// [RULE15] Zero offset puts sampling 90 degrees after the forwarded clock.
// [RULE16] Phase offset sits in bits 3..0 of register sample_phase_offset, sign-magnitude.
// [RULE17] Phase is 90 degrees plus setting times 11.25, magnitude below 7.
// [RULE18] Host keeps data transitions out of the keep-out window.
// [RULE19] Frame marker is sampled with the same edges as the data lanes.
package lvds_port_pkg;
  localparam logic [14:0] ADDR_PHASE = 15'h000a;
  localparam logic [14:0] ADDR_CFG = 15'h0026;
  localparam int CFG_BYTE_BIT = 0;
  localparam int CFG_FMT_BIT = 7;
  localparam int PHASE_SIGN_BIT = 3;
  localparam logic [7:0] PHASE_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [3:0] NOM_STEPS = 4'h8;
  localparam logic [2:0] MAX_MAG = 3'h6;
  localparam logic [4:0] INSTR_BITS = 5'h10;
  localparam logic [4:0] XFER_BITS = 5'h18;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio;
  } spi_pins_t;

  typedef struct packed {
    logic frame;
    logic [15:0] data;
  } link_in_t;

  typedef struct packed {
    logic valid;
    logic two;
    logic [15:0] s0;
    logic [15:0] s1;
  } sample_out_t;

  typedef struct packed {
    spi_pins_t sy1;
    spi_pins_t sy2;
    spi_pins_t prev;
    logic [4:0] cnt;
    logic [14:0] sh;
    logic rw;
    logic [14:0] addr;
    logic [7:0] rd;
    logic [7:0] phase;
    logic [7:0] cfg;
    logic [3:0] dll;
    logic sdo;
    logic oe;
  } ctl_t;

  typedef struct packed {
    logic rs1;
    logic rs2;
    logic [1:0] cf1;
    logic [1:0] cf2;
    logic [15:0] rdat;
    logic rfr;
    logic last;
    logic locked;
    logic odd;
    logic [7:0] held;
    sample_out_t out;
  } link_t;
endpackage

/* File: verification/lvds_host_model.sv */
// Behavioural data host that drives the double-rate sample link.
`timescale 1ns/1ps
module lvds_host_model (
  input wire logic forwarded_data_clock,
  input wire logic run,
  input wire logic byte_mode,
  input wire logic odd,
  output lvds_port_pkg::link_in_t lvds
);
  import lvds_port_pkg::*;
  logic lvl;
  logic go;
  logic [14:0] c;
  logic [8:0] b;
  initial begin
    lvds = '0;
    go = 1'b0;
    c = '0;
    b = '0;
  end
  // Lanes move a quarter period after each edge, so every edge sees mid-eye.
  always @(forwarded_data_clock) begin
    lvl = forwarded_data_clock;
    #16;
    if (!run) begin
      go = 1'b0;
      b = '0;
    end else if (lvl == odd) begin
      go = 1'b1;
    end
    if (!byte_mode) begin
      lvds.frame = 1'b0;
      lvds.data = {c, lvl};
      c = c + 15'(lvl);
    end else if (go) begin
      // Upper lanes carry junk; the marker is high for every other sample.
      lvds.data = {~lvds.data[15:8], b[0] ? ~b[8:1] : b[8:1]};
      lvds.frame = ~b[1];
      b = b + 9'h001;
    end else begin
      lvds.data = ~lvds.data;
      lvds.frame = 1'b0;
    end
  end
endmodule

/* File: verification/test_lvds_sample_input_port.sv */
// Self-checking bench for the sample input port.
`timescale 1ns/1ps
module test_lvds_sample_input_port;
  import lvds_port_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic fdc = 1'b0;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic host_sdio = 1'b0;
  logic run = 1'b0;
  logic odd = 1'b0;
  logic mon = 1'b0;
  logic [7:0] cfg_v = 8'h00;
  logic [7:0] rd;
  logic [15:0] r0;
  logic [15:0] r1;
  logic [7:0] pv [6] = '{8'h53, 8'h0b, 8'hf7, 8'h08, 8'h0e, 8'h06};
  link_in_t lvds;
  logic sdio_out;
  logic sdio_oe;
  logic [3:0] steps;
  sample_out_t samples;
  int error_cnt = 0;
  int total_checks = 0;
  int nval = 0;
  wire sdio_line = sdio_oe ? sdio_out : host_sdio;
  always #20 clock = ~clock;
  initial begin
    #7;
    forever #32 fdc = ~fdc;
  end
  lvds_sample_input_port i_dut (.clock(clock), .rst(rst), .ce(ce),
    .forwarded_data_clock(fdc), .lvds(lvds), .sclk(sclk), .cs_n(cs_n),
    .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .sampling_phase_steps(steps), .samples(samples));
  lvds_host_model i_host (.forwarded_data_clock(fdc), .run(run),
    .byte_mode(cfg_v[CFG_BYTE_BIT]), .odd(odd), .lvds(lvds));
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Serial clock runs at clock/12, well inside the synchroniser's limit.
  task automatic spi(input logic [15:0] ins, input logic [7:0] wd);
    logic [23:0] sh;
    sh = {ins, wd};
    @(posedge clock);
    cs_n <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clock);
      sclk <= 1'b0;
      host_sdio <= (i > 15 && ins[15]) ? i[0] : sh[23 - i];
      repeat (6) @(posedge clock);
      if (i > 15)
        rd[23 - i] = sdio_line;
      sclk <= 1'b1;
      repeat (5) @(posedge clock);
    end
    repeat (6) @(posedge clock);
    cs_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  task automatic rdchk(input string nm, input logic [14:0] a, input logic [7:0] e);
    spi({1'b1, a}, 8'h00);
    check(nm, {8'h00, rd}, {8'h00, e});
    check("oe released", {15'h0000, sdio_oe}, 16'h0000);
  endtask
  function automatic logic [3:0] exp_steps(input logic [3:0] v);
    logic [3:0] m;
    m = (v[2:0] == 3'h7) ? {1'b0, MAX_MAG} : {1'b0, v[2:0]};
    return v[3] ? NOM_STEPS - m : NOM_STEPS + m;
  endfunction
  task automatic link_run(input logic [7:0] cv, input logic od);
    spi({1'b0, ADDR_CFG}, cv);
    cfg_v = cv;
    odd <= od;
    repeat (10) @(posedge fdc);
    run <= 1'b1;
    repeat (6) @(posedge fdc);
    nval = 0;
    mon = 1'b1;
    repeat (30) @(posedge fdc);
    mon = 1'b0;
    run <= 1'b0;
    check("valid count", 16'(nval > 20), 16'h0001);
  endtask
  always @(negedge fdc) begin
    if (mon && samples.valid === 1'b1) begin
      nval++;
      r0 = samples.s0 ^ {cfg_v[CFG_FMT_BIT], 15'h0000};
      r1 = samples.s1 ^ {cfg_v[CFG_FMT_BIT], 15'h0000};
      if (cfg_v[CFG_BYTE_BIT]) begin
        check("two", {15'h0000, samples.two}, 16'h0000);
        check("byte pair", {r0[15], r0[7:0]}, {1'b0, ~r0[15:8]});
      end else begin
        check("two", {15'h0000, samples.two}, 16'h0001);
        check("word ends", {r0[15], r0[0]}, 16'h0000);
        check("word pair", r1, r0 | 16'h0001);
      end
    end
  end
  initial begin
    #2000000;
    error_cnt++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    check("steps", {12'h000, steps}, {12'h000, NOM_STEPS});
    rdchk("phase reg", ADDR_PHASE, PHASE_RESET);
    rdchk("cfg reg", ADDR_CFG, CFG_RESET);
    foreach (pv[i]) begin
      spi({1'b0, ADDR_PHASE}, pv[i]);
      check("steps", {12'h000, steps}, {12'h000, exp_steps(pv[i][3:0])});
      rdchk("phase reg", ADDR_PHASE, pv[i]);
    end
    ce <= 1'b0;
    spi({1'b0, ADDR_PHASE}, 8'h03);
    ce <= 1'b1;
    rdchk("frozen phase", ADDR_PHASE, pv[5]);
    spi({1'b0, 15'h0015}, 8'h5a);
    rdchk("unmapped", 15'h0015, 8'h00);
    link_run(8'h00, 1'b0);
    link_run(8'h80, 1'b0);
    link_run(8'h01, 1'b0);
    link_run(8'h00, 1'b0);
    link_run(8'h81, 1'b1);
    close_out();
  end
endmodule
